// [pkg/rmb_defines.svh]
// offsets, field positions, reset values and timing counts of the
// runtime misc register bank; included by the bank and its package users
`ifndef RMB_DEFINES_SVH
`define RMB_DEFINES_SVH

// register offsets (byte addresses on the plain register port)
`define RMB_OFS_KEY_SCAN_CODE 8'h11
`define RMB_OFS_FAN_ONE_LOW 8'h12
`define RMB_OFS_FAN_ONE_HIGH 8'h13
`define RMB_OFS_FAN_TWO_LOW 8'h14
`define RMB_OFS_FAN_TWO_HIGH 8'h15
`define RMB_OFS_PWR_EVT_CTRL 8'h16
`define RMB_OFS_MISC_EDGE_STS 8'h17
`define RMB_OFS_WAKE_ENABLE 8'h20
`define RMB_OFS_IRQ_STATUS 8'h21
`define RMB_OFS_IRQ_MASK 8'h22

// reset values
`define RMB_RST_KEY_SCAN_CODE 8'h00
`define RMB_RST_PWR_EVT_CTRL 8'h84
`define RMB_RST_MISC_EDGE_STS 8'h00
`define RMB_RST_WAKE_ENABLE 8'h00
`define RMB_RST_IRQ_STATUS 8'h00
`define RMB_RST_IRQ_MASK 8'h00
`define RMB_READ_ZERO 8'h00

// power event control fields
`define RMB_PEC_POLARITY 1
`define RMB_PEC_DELAY_SEL 2
`define RMB_PEC_LOCK 3
`define RMB_PEC_OPEN_DRAIN 7

// misc edge status fields
`define RMB_MES_EDGE_A 0
`define RMB_MES_EDGE_B 1
`define RMB_MES_W1C_MASK 8'h03

// wake enable fields
`define RMB_WEN_EDGE_A 0
`define RMB_WEN_EDGE_B 1
`define RMB_WEN_MASTER 7
`define RMB_WEN_MASK 8'h83

// interrupt status fields
`define RMB_IRQ_EDGE_A 0
`define RMB_IRQ_EDGE_B 1
`define RMB_IRQ_PWR_EVT 2
`define RMB_IRQ_PG_READY 3
`define RMB_IRQ_MASK_BITS 8'h0F

// timing
`define RMB_CLK_MHZ 50
`define RMB_PG_DELAY_US 100
`define RMB_PG_DELAY_CYC (`RMB_PG_DELAY_US * `RMB_CLK_MHZ)
`define RMB_SYNC_PRIME_CYC 3

`endif

// [pkg/rmb_pkg.sv]
// types shared by the runtime misc register bank and its edge detectors
// assumes nothing of its surroundings
package rmb_pkg;
	typedef logic [7:0] rmb_byte_t;
	typedef logic [15:0] rmb_count_t;
	typedef enum logic [1:0] {
		RMB_PG_LOW = 2'b00,
		RMB_PG_WAIT = 2'b01,
		RMB_PG_HIGH = 2'b10
	} rmb_pg_state_t;
endpackage

// [rtl/rmb_edge_detect.sv]
// either-edge detector for one asynchronous pin
// assumes the pin is slow against sys_clk; one pulse per level change
`timescale 1ns/1ps
`default_nettype none
`include "rmb_defines.svh"

module rmb_edge_detect
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin,
	output logic edge_pulse
);
	import rmb_pkg::*;

	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic [1:0] prime_r;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			prev_r <= 1'b0;
		else
			prev_r <= sync_r;
	end

	// no edge until the chain holds the real pin level after reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			prime_r <= 2'h0;
		else if (prime_r != 2'(`RMB_SYNC_PRIME_CYC))
			prime_r <= prime_r + 2'h1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			edge_pulse <= 1'b0;
		else
			edge_pulse <= (prime_r == 2'(`RMB_SYNC_PRIME_CYC))
				&& (sync_r != prev_r);
	end
endmodule

`default_nettype wire

// [rtl/rmb_bank.sv]
// runtime misc register bank: scan code, fan counts, power event control,
// either-edge status, wake enables and a level interrupt
// assumes fan counts come from logic on sys_clk; pins are asynchronous
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rmb_defines.svh"

module rmb_bank
#(
	parameter int unsigned PG_DELAY_CYCLES = `RMB_PG_DELAY_CYC,
	parameter int unsigned PG_CNT_W = 24
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire rmb_pkg::rmb_byte_t reg_addr,
	input wire rmb_pkg::rmb_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output rmb_pkg::rmb_byte_t reg_rdata,
	input wire rmb_pkg::rmb_count_t fan_one_count,
	input wire rmb_pkg::rmb_count_t fan_two_count,
	input wire logic edge_input_a,
	input wire logic edge_input_b,
	input wire logic platform_good_in,
	output logic platform_good_out,
	output logic power_event_out,
	output logic power_event_oe,
	output logic irq
);
	import rmb_pkg::*;

	rmb_byte_t key_scan_code_r;
	rmb_byte_t power_event_control_r;
	rmb_byte_t misc_edge_status_r;
	rmb_byte_t wake_enable_r;
	rmb_byte_t irq_status_r;
	rmb_byte_t irq_mask_r;
	rmb_byte_t fan_one_high_r;
	rmb_byte_t fan_two_high_r;
	rmb_byte_t rdata_nxt;

	logic wr_key;
	logic wr_ctrl;
	logic wr_sts;
	logic wr_wen;
	logic wr_mask;
	logic rd_irq_sts;
	logic rd_fan_one_low;
	logic rd_fan_two_low;

	logic edge_a_pulse;
	logic edge_b_pulse;
	logic pg_meta_r;
	logic pg_sync_r;
	rmb_pg_state_t pg_state_r;
	rmb_pg_state_t pg_state_nxt;
	logic [PG_CNT_W-1:0] pg_cnt_r;
	logic pg_ready_pulse;

	logic event_active;
	logic event_active_r;
	logic event_level;
	logic polarity;
	logic delay_sel;
	logic lock;
	logic open_drain;

	// register port decode
	assign wr_key = reg_wr && (reg_addr == `RMB_OFS_KEY_SCAN_CODE);
	assign wr_ctrl = reg_wr && (reg_addr == `RMB_OFS_PWR_EVT_CTRL);
	assign wr_sts = reg_wr && (reg_addr == `RMB_OFS_MISC_EDGE_STS);
	assign wr_wen = reg_wr && (reg_addr == `RMB_OFS_WAKE_ENABLE);
	assign wr_mask = reg_wr && (reg_addr == `RMB_OFS_IRQ_MASK);
	assign rd_irq_sts = reg_rd && (reg_addr == `RMB_OFS_IRQ_STATUS);
	assign rd_fan_one_low = reg_rd && (reg_addr == `RMB_OFS_FAN_ONE_LOW);
	assign rd_fan_two_low = reg_rd && (reg_addr == `RMB_OFS_FAN_TWO_LOW);

	assign polarity = power_event_control_r[`RMB_PEC_POLARITY];
	assign delay_sel = power_event_control_r[`RMB_PEC_DELAY_SEL];
	assign lock = power_event_control_r[`RMB_PEC_LOCK];
	assign open_drain = power_event_control_r[`RMB_PEC_OPEN_DRAIN];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			key_scan_code_r <= `RMB_RST_KEY_SCAN_CODE;
		else if (wr_key)
			key_scan_code_r <= reg_wdata;
	end

	// free bits follow writes; reserved bits keep reset zero
	// lock freezes delay select and itself until standby reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			power_event_control_r <= `RMB_RST_PWR_EVT_CTRL;
		else if (wr_ctrl)
		begin
			power_event_control_r[`RMB_PEC_POLARITY] <=
				reg_wdata[`RMB_PEC_POLARITY];
			power_event_control_r[`RMB_PEC_OPEN_DRAIN] <=
				reg_wdata[`RMB_PEC_OPEN_DRAIN];
			if (!lock)
			begin
				power_event_control_r[`RMB_PEC_DELAY_SEL] <=
					reg_wdata[`RMB_PEC_DELAY_SEL];
				power_event_control_r[`RMB_PEC_LOCK] <=
					reg_wdata[`RMB_PEC_LOCK];
			end
		end
	end

	// either-edge detectors, synchronised inside
	rmb_edge_detect u_edge_a
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.pin(edge_input_a),
		.edge_pulse(edge_a_pulse)
	);

	rmb_edge_detect u_edge_b
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.pin(edge_input_b),
		.edge_pulse(edge_b_pulse)
	);

	// sticky edge status; a new edge beats a same-cycle clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			misc_edge_status_r <= `RMB_RST_MISC_EDGE_STS;
		else
		begin
			if (edge_a_pulse)
				misc_edge_status_r[`RMB_MES_EDGE_A] <= 1'b1;
			else if (wr_sts && reg_wdata[`RMB_MES_EDGE_A])
				misc_edge_status_r[`RMB_MES_EDGE_A] <= 1'b0;
			if (edge_b_pulse)
				misc_edge_status_r[`RMB_MES_EDGE_B] <= 1'b1;
			else if (wr_sts && reg_wdata[`RMB_MES_EDGE_B])
				misc_edge_status_r[`RMB_MES_EDGE_B] <= 1'b0;
			// reserved status bits held at zero
			misc_edge_status_r[7:2] <= 6'h00;
		end
	end

	// wake enables and master enable
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			wake_enable_r <= `RMB_RST_WAKE_ENABLE;
		else if (wr_wen)
			wake_enable_r <= reg_wdata & `RMB_WEN_MASK;
	end

	// status, enable and master enable must coincide
	assign event_active = wake_enable_r[`RMB_WEN_MASTER]
		&& ((misc_edge_status_r[`RMB_MES_EDGE_A]
			&& wake_enable_r[`RMB_WEN_EDGE_A])
		|| (misc_edge_status_r[`RMB_MES_EDGE_B]
			&& wake_enable_r[`RMB_WEN_EDGE_B]));

	// pin is active low unless inverted
	assign event_level = polarity ? event_active_r : !event_active_r;

	// open drain only ever pulls low; push-pull always drives
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			event_active_r <= 1'b0;
			power_event_out <= 1'b0;
			power_event_oe <= 1'b0;
		end
		else
		begin
			event_active_r <= event_active;
			power_event_out <= !open_drain && event_level;
			power_event_oe <= !open_drain || !event_level;
		end
	end

	// platform good pin synchroniser
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pg_meta_r <= 1'b0;
			pg_sync_r <= 1'b0;
		end
		else
		begin
			pg_meta_r <= platform_good_in;
			pg_sync_r <= pg_meta_r;
		end
	end

	// delayed path waits out the count after a rise; a fall is at once
	always_comb
	begin
		pg_state_nxt = pg_state_r;
		unique case (pg_state_r)
			RMB_PG_LOW:
				if (pg_sync_r)
					pg_state_nxt = delay_sel ? RMB_PG_WAIT : RMB_PG_HIGH;
			RMB_PG_WAIT:
				if (!pg_sync_r)
					pg_state_nxt = RMB_PG_LOW;
				else if (!delay_sel
					|| pg_cnt_r == PG_CNT_W'(PG_DELAY_CYCLES - 1))
					pg_state_nxt = RMB_PG_HIGH;
			RMB_PG_HIGH:
				if (!pg_sync_r)
					pg_state_nxt = RMB_PG_LOW;
			default:
				pg_state_nxt = RMB_PG_LOW;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pg_state_r <= RMB_PG_LOW;
			platform_good_out <= 1'b0;
		end
		else
		begin
			pg_state_r <= pg_state_nxt;
			platform_good_out <= (pg_state_nxt == RMB_PG_HIGH);
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pg_cnt_r <= '0;
		else if (pg_state_r == RMB_PG_WAIT)
			pg_cnt_r <= pg_cnt_r + PG_CNT_W'(1);
		else
			pg_cnt_r <= '0;
	end

	assign pg_ready_pulse = (pg_state_r != RMB_PG_HIGH)
		&& (pg_state_nxt == RMB_PG_HIGH);

	// interrupt status: set wins over the clear-on-read
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			irq_status_r <= `RMB_RST_IRQ_STATUS;
		else
		begin
			if (edge_a_pulse)
				irq_status_r[`RMB_IRQ_EDGE_A] <= 1'b1;
			else if (rd_irq_sts)
				irq_status_r[`RMB_IRQ_EDGE_A] <= 1'b0;
			if (edge_b_pulse)
				irq_status_r[`RMB_IRQ_EDGE_B] <= 1'b1;
			else if (rd_irq_sts)
				irq_status_r[`RMB_IRQ_EDGE_B] <= 1'b0;
			if (event_active && !event_active_r)
				irq_status_r[`RMB_IRQ_PWR_EVT] <= 1'b1;
			else if (rd_irq_sts)
				irq_status_r[`RMB_IRQ_PWR_EVT] <= 1'b0;
			if (pg_ready_pulse)
				irq_status_r[`RMB_IRQ_PG_READY] <= 1'b1;
			else if (rd_irq_sts)
				irq_status_r[`RMB_IRQ_PG_READY] <= 1'b0;
			irq_status_r[7:4] <= 4'h0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			irq_mask_r <= `RMB_RST_IRQ_MASK;
		else if (wr_mask)
			irq_mask_r <= reg_wdata & `RMB_IRQ_MASK_BITS;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irq_status_r & irq_mask_r);
	end

	// a low-byte read holds the high byte so the pair stays coherent
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			fan_one_high_r <= `RMB_READ_ZERO;
			fan_two_high_r <= `RMB_READ_ZERO;
		end
		else
		begin
			if (rd_fan_one_low)
				fan_one_high_r <= fan_one_count[15:8];
			if (rd_fan_two_low)
				fan_two_high_r <= fan_two_count[15:8];
		end
	end

	// count bytes have no write decode; unmapped reads give zero
	always_comb
	begin
		rdata_nxt = `RMB_READ_ZERO;
		case (reg_addr)
			`RMB_OFS_KEY_SCAN_CODE:
				rdata_nxt = key_scan_code_r;
			`RMB_OFS_FAN_ONE_LOW:
				rdata_nxt = fan_one_count[7:0];
			`RMB_OFS_FAN_ONE_HIGH:
				rdata_nxt = fan_one_high_r;
			`RMB_OFS_FAN_TWO_LOW:
				rdata_nxt = fan_two_count[7:0];
			`RMB_OFS_FAN_TWO_HIGH:
				rdata_nxt = fan_two_high_r;
			`RMB_OFS_PWR_EVT_CTRL:
				rdata_nxt = power_event_control_r;
			`RMB_OFS_MISC_EDGE_STS:
				rdata_nxt = misc_edge_status_r;
			`RMB_OFS_WAKE_ENABLE:
				rdata_nxt = wake_enable_r;
			`RMB_OFS_IRQ_STATUS:
				rdata_nxt = irq_status_r;
			`RMB_OFS_IRQ_MASK:
				rdata_nxt = irq_mask_r;
		endcase
	end

	// data valid only in the cycle after the read strobe
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= `RMB_READ_ZERO;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= `RMB_READ_ZERO;
	end
endmodule

`default_nettype wire

// [dv/rmb_bank_asserts.sv]
// port checker of the runtime misc register bank
// assumes binding to rmb_bank; sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "rmb_defines.svh"

module rmb_bank_asserts
import rmb_pkg::*;
#(
	parameter int unsigned PG_DELAY_CYCLES = `RMB_PG_DELAY_CYC
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire rmb_pkg::rmb_byte_t reg_addr,
	input wire rmb_pkg::rmb_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire rmb_pkg::rmb_byte_t reg_rdata,
	input wire rmb_pkg::rmb_count_t fan_one_count,
	input wire rmb_pkg::rmb_count_t fan_two_count,
	input wire logic edge_input_a,
	input wire logic edge_input_b,
	input wire logic platform_good_in,
	input wire logic platform_good_out,
	input wire logic power_event_out,
	input wire logic power_event_oe,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_scan_readback: assert property (
		reg_wr && reg_addr == 8'h11 ##1 !reg_wr ##1
		reg_rd && reg_addr == 8'h11 |=> reg_rdata == $past(reg_wdata, 3))
		else $error("scan code readback differs");
	a_fan_one_low: assert property (
		reg_rd && reg_addr == 8'h12 |=> reg_rdata == $past(fan_one_count[7:0]))
		else $error("first fan low byte wrong");
	a_fan_two_low: assert property (
		reg_rd && reg_addr == 8'h14 |=> reg_rdata == $past(fan_two_count[7:0]))
		else $error("second fan low byte wrong");
	a_status_reserved_zero: assert property (
		reg_rd && reg_addr == 8'h17 |=> reg_rdata[7:2] == 6'h00)
		else $error("status reserved bits not zero");
	a_ctrl_reserved_zero: assert property (
		reg_rd && reg_addr == 8'h16 |=> reg_rdata[6:4] == 3'h0 && !reg_rdata[0])
		else $error("control reserved bits not zero");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_drive_kind: assert property (
		power_event_out |-> power_event_oe)
		else $error("output high while not driven");
	a_good_rise_cause: assert property (
		$rose(platform_good_out) |-> platform_good_in)
		else $error("platform good rose without input");
	a_good_fall: assert property (
		!platform_good_in [*5] |-> !platform_good_out)
		else $error("platform good stayed high");
endmodule

bind rmb_bank rmb_bank_asserts #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .fan_one_count(fan_one_count),
	.fan_two_count(fan_two_count), .edge_input_a(edge_input_a),
	.edge_input_b(edge_input_b), .platform_good_in(platform_good_in),
	.platform_good_out(platform_good_out),
	.power_event_out(power_event_out), .power_event_oe(power_event_oe),
	.irq(irq));

`default_nettype wire

// [dv/runtime_misc_register_bank_test.sv]
// self-checking bench of the runtime misc register bank
// assumes the bound checker; the bench drives every input itself
`timescale 1ns/1ps
`default_nettype none

module runtime_misc_register_bank_test;
	import rmb_pkg::*;
	localparam int unsigned PG_CYC = 8;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	rmb_byte_t reg_addr = 8'h00;
	rmb_byte_t reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	rmb_byte_t reg_rdata;
	rmb_count_t fan_one_count = 16'h0000;
	rmb_count_t fan_two_count = 16'h0000;
	logic edge_input_a = 1'b0;
	logic edge_input_b = 1'b0;
	logic platform_good_in = 1'b0;
	logic platform_good_out, power_event_out, power_event_oe, irq;
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;
	rmb_byte_t vals [4] = '{8'h5A, 8'hA5, 8'h01, 8'h80};
	rmb_byte_t ctrl [4] = '{8'h84, 8'h86, 8'h04, 8'h06};
	rmb_byte_t pins [4] = '{8'h00, 8'h02, 8'h03, 8'h02};

	always #10 sys_clk = ~sys_clk;

	rmb_bank #(.PG_DELAY_CYCLES(PG_CYC), .PG_CNT_W(24)) dut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fan_one_count(fan_one_count),
		.fan_two_count(fan_two_count), .edge_input_a(edge_input_a),
		.edge_input_b(edge_input_b), .platform_good_in(platform_good_in),
		.platform_good_out(platform_good_out),
		.power_event_out(power_event_out), .power_event_oe(power_event_oe),
		.irq(irq));

	task automatic end_sim();
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// the whole run needs well under two thousand cycles
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count = bad_count + 1;
			end_sim();
		end
	end

	task automatic chk(input rmb_byte_t got, input rmb_byte_t exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input rmb_byte_t a, input rmb_byte_t v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rc(input rmb_byte_t a, input rmb_byte_t exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// pins held still so detectors see no edge across reset
	task automatic do_reset();
		@(posedge sys_clk);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(6);
	endtask
	task automatic pin_out(input rmb_byte_t exp);
		chk({6'h00, power_event_oe, power_event_out}, exp);
	endtask

	task automatic t_defaults();
		rc(8'h11, 8'h00);
		rc(8'h16, 8'h84);
		rc(8'h17, 8'h00);
		rc(8'h12, 8'h00);
		rc(8'h00, 8'h00);
		pin_out(8'h00);
	endtask
	task automatic t_scan();
		foreach (vals[i])
		begin
			wr(8'h11, vals[i]);
			rc(8'h11, vals[i]);
		end
	endtask
	task automatic t_fan();
		@(posedge sys_clk);
		fan_one_count <= 16'h1234;
		fan_two_count <= 16'hBEEF;
		for (int a = 8'h12; a <= 8'h15; a++)
			wr(8'(a), 8'hFF);
		rc(8'h12, 8'h34);
		@(posedge sys_clk);
		fan_one_count <= 16'h5678;
		rc(8'h13, 8'h12);
		rc(8'h14, 8'hEF);
		rc(8'h15, 8'hBE);
		rc(8'h12, 8'h78);
		rc(8'h13, 8'h56);
	endtask
	task automatic t_edges();
		rc(8'h21, 8'h00);
		wr(8'h22, 8'h01);
		@(posedge sys_clk);
		edge_input_a <= 1'b1;
		tick(6);
		rc(8'h17, 8'h01);
		chk({7'h00, irq}, 8'h01);
		rc(8'h21, 8'h01);
		tick(2);
		chk({7'h00, irq}, 8'h00);
		@(posedge sys_clk);
		edge_input_b <= 1'b0 ^ 1'b1;
		tick(6);
		rc(8'h17, 8'h03);
		chk({7'h00, irq}, 8'h00);
		wr(8'h17, 8'hFC);
		rc(8'h17, 8'h03);
		wr(8'h17, 8'h02);
		rc(8'h17, 8'h01);
		wr(8'h17, 8'h01);
		rc(8'h17, 8'h00);
		@(posedge sys_clk);
		edge_input_a <= 1'b0;
		tick(6);
		rc(8'h17, 8'h01);
		wr(8'h17, 8'hFF);
		rc(8'h17, 8'h00);
		rc(8'h21, 8'h03);
	endtask
	task automatic t_pwr();
		foreach (ctrl[i])
		begin
			wr(8'h16, ctrl[i]);
			tick(3);
			pin_out(pins[i]);
		end
		wr(8'h20, 8'h01);
		@(posedge sys_clk);
		edge_input_a <= 1'b1;
		tick(7);
		pin_out(8'h02);
		wr(8'h20, 8'h81);
		tick(3);
		pin_out(8'h03);
		wr(8'h20, 8'h80);
		tick(3);
		pin_out(8'h02);
		wr(8'h20, 8'h81);
		wr(8'h17, 8'h01);
		tick(3);
		pin_out(8'h02);
		// open drain pulls low only while the event is active
		wr(8'h16, 8'h84);
		@(posedge sys_clk);
		edge_input_a <= 1'b0;
		tick(7);
		pin_out(8'h02);
		wr(8'h17, 8'h01);
		tick(3);
		pin_out(8'h00);
		rc(8'h21, 8'h05);
		wr(8'h20, 8'h00);
	endtask
	task automatic t_lock();
		wr(8'h16, 8'hF3);
		rc(8'h16, 8'h82);
		@(posedge sys_clk);
		platform_good_in <= 1'b1;
		tick(5);
		chk({7'h00, platform_good_out}, 8'h01);
		platform_good_in <= 1'b0;
		tick(5);
		wr(8'h16, 8'h8C);
		rc(8'h16, 8'h8C);
		wr(8'h16, 8'h80);
		rc(8'h16, 8'h8C);
		wr(8'h16, 8'h82);
		rc(8'h16, 8'h8E);
		// two sync flops and the step into the wait state add three edges
		@(posedge sys_clk);
		platform_good_in <= 1'b1;
		tick(PG_CYC + 2);
		#1 chk({7'h00, platform_good_out}, 8'h00);
		tick(1);
		#1 chk({7'h00, platform_good_out}, 8'h01);
		@(posedge sys_clk);
		platform_good_in <= 1'b0;
		tick(5);
		rc(8'h21, 8'h08);
		do_reset();
		rc(8'h16, 8'h84);
		wr(8'h16, 8'h80);
		rc(8'h16, 8'h80);
	endtask

	initial
	begin
		do_reset();
		t_defaults();
		t_scan();
		t_fan();
		t_edges();
		t_pwr();
		t_lock();
		end_sim();
	end
endmodule

`default_nettype wire
